// file: shared/host_ram_pkg.sv
package host_ram_pkg;
  // host register indices in the register index field
  localparam logic [5:0] IDX_ACCESS_CTRL = 6'h04;
  localparam logic [5:0] IDX_DATA_WINDOW = 6'h05;
  localparam logic [5:0] IDX_RAM_POINTER = 6'h06;
  // field positions of shared_ram_access_control
  localparam int BIT_LOCK = 7;
  localparam int BIT_WRITE_CMD = 5;
  localparam int BIT_READ_CMD = 3;
  localparam int BIT_STEP_DIR = 0;
  // reset values
  localparam logic [31:0] RST_ACCESS_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_DATA_WINDOW = 32'h0000_0000;
  localparam logic [31:0] RST_RAM_POINTER = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // pointer step per access in bytes
  localparam logic [31:0] POINTER_STEP = 32'h0000_0004;
  localparam int DEFAULT_DEPTH = 256;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] idx;
    logic [31:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic lock;
    logic write_cmd;
    logic read_cmd;
    logic step_dir;
  } access_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RAM_WRITE,
    ST_RAM_READ
  } access_state_t;
endpackage

// file: rtl/shared_ram_store.sv
`timescale 1ns/100ps
module shared_ram_store
  import host_ram_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int IDX_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [IDX_W-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);

  logic [31:0] mem_q [DEPTH];
  logic [31:0] mem_d [DEPTH];

  initial begin
    if (DEPTH < 2 || DEPTH > (1 << IDX_W)) begin
      $error("depth does not fit the index width");
    end
  end

  always_comb begin
    mem_d = mem_q;
    if (we && (int'(addr) < DEPTH)) begin
      mem_d[addr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= READ_ZERO;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

  assign rdata = (int'(addr) < DEPTH) ? mem_q[addr] : READ_ZERO;
endmodule // shared_ram_store

// file: rtl/host_ram_access_control.sv
`timescale 1ns/100ps
// Contract
// - the access control register is 32 bits wide and read-only to the cpu.
// - bits 31 to 8 read as zero and are written as zero.
// - bits 6 and 4 are reserved, read as zero and are written as zero.
// - lock set holds the read and write command bits until lock clears.
// - lock with read command enters consecutive read mode.
// - write command stores the data window into ram at the pointer.
// - lock with write command enters consecutive write mode until cleared.
// - write command without lock writes once then self-clears.
// - read command loads the ram word at the pointer, once without lock.
// - under lock each ram access steps the pointer by four, bit 0 = down.
// - lock, command and step bits are written only by the host, rs low.
module host_ram_access_control
  import host_ram_pkg::*;
#(
  parameter int DEPTH = DEFAULT_DEPTH,
  parameter int IDX_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire host_req_t host_req,
  input wire logic register_select_pin,
  output logic [31:0] host_rdata,
  output logic host_rvalid,
  output logic [31:0] cpu_access_ctrl,
  output logic consecutive_read,
  output logic consecutive_write
);

  initial begin
    if (IDX_W + 2 > 32) begin
      $error("ram index too wide for the pointer");
    end
  end

  // ----------------------------------------------------------------
  // host decode
  // ----------------------------------------------------------------
  logic sel_ok;
  logic wr_ctrl;
  logic wr_window;
  logic wr_pointer;
  logic rd_window;
  logic rd_any;

  assign sel_ok = !register_select_pin;
  assign wr_ctrl = host_req.wr && sel_ok && host_req.idx == IDX_ACCESS_CTRL;
  assign wr_window = host_req.wr && sel_ok && host_req.idx == IDX_DATA_WINDOW;
  assign wr_pointer = host_req.wr && sel_ok
                      && host_req.idx == IDX_RAM_POINTER;
  assign rd_window = host_req.rd && sel_ok && host_req.idx == IDX_DATA_WINDOW;
  assign rd_any = host_req.rd && sel_ok;

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  access_ctrl_t ctrl_q;
  access_ctrl_t ctrl_d;
  access_state_t state_q;
  access_state_t state_d;
  logic [31:0] window_q;
  logic [31:0] window_d;
  logic [31:0] pointer_q;
  logic [31:0] pointer_d;
  logic ram_we;
  logic [31:0] ram_rdata;
  logic [31:0] ctrl_word;

  // reserved and upper bits stay zero in the image
  always_comb begin
    ctrl_word = READ_ZERO;
    ctrl_word[BIT_LOCK] = ctrl_q.lock;
    ctrl_word[BIT_WRITE_CMD] = ctrl_q.write_cmd;
    ctrl_word[BIT_READ_CMD] = ctrl_q.read_cmd;
    ctrl_word[BIT_STEP_DIR] = ctrl_q.step_dir;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    state_d = state_q;
    window_d = window_q;
    pointer_d = pointer_q;
    ram_we = 1'b0;
    case (state_q)
      ST_RAM_WRITE: begin
        ram_we = 1'b1;
        state_d = ST_IDLE;
        if (ctrl_q.lock) begin
          pointer_d = ctrl_q.step_dir ? pointer_q - POINTER_STEP
                                      : pointer_q + POINTER_STEP;
        end else begin
          ctrl_d.write_cmd = 1'b0;
        end
      end
      ST_RAM_READ: begin
        window_d = ram_rdata;
        state_d = ST_IDLE;
        if (ctrl_q.lock) begin
          pointer_d = ctrl_q.step_dir ? pointer_q - POINTER_STEP
                                      : pointer_q + POINTER_STEP;
        end else begin
          ctrl_d.read_cmd = 1'b0;
        end
      end
      ST_IDLE: begin
        // only the host can change the control bits; no cpu write path
        if (wr_ctrl) begin
          ctrl_d.lock = host_req.wdata[BIT_LOCK];
          ctrl_d.write_cmd = host_req.wdata[BIT_WRITE_CMD];
          ctrl_d.read_cmd = host_req.wdata[BIT_READ_CMD];
          ctrl_d.step_dir = host_req.wdata[BIT_STEP_DIR];
          if (host_req.wdata[BIT_WRITE_CMD]) begin
            state_d = ST_RAM_WRITE;
          end else if (host_req.wdata[BIT_READ_CMD]) begin
            state_d = ST_RAM_READ;
          end
        end else if (wr_window) begin
          window_d = host_req.wdata;
          if (ctrl_q.lock && ctrl_q.write_cmd) begin
            state_d = ST_RAM_WRITE;
          end
        end else if (wr_pointer) begin
          pointer_d = host_req.wdata;
        end else if (rd_window && ctrl_q.lock && ctrl_q.read_cmd) begin
          state_d = ST_RAM_READ;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= access_ctrl_t'(4'h0);
      state_q <= ST_IDLE;
      window_q <= RST_DATA_WINDOW;
      pointer_q <= RST_RAM_POINTER;
    end else begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      window_q <= window_d;
      pointer_q <= pointer_d;
    end
  end

  // ----------------------------------------------------------------
  // shared ram
  // ----------------------------------------------------------------
  shared_ram_store #(
    .DEPTH(DEPTH),
    .IDX_W(IDX_W)
  ) u_ram (
    .clk(clk),
    .rst_n(rst_n),
    .we(ram_we),
    .addr(pointer_q[IDX_W+1:2]),
    .wdata(window_q),
    .rdata(ram_rdata)
  );

  // ----------------------------------------------------------------
  // read answers and status outputs
  // ----------------------------------------------------------------
  logic [31:0] host_rdata_q;
  logic [31:0] host_rdata_d;
  logic host_rvalid_q;
  logic [31:0] cpu_view_q;
  logic cons_rd_q;
  logic cons_wr_q;

  always_comb begin
    host_rdata_d = READ_ZERO;
    if (rd_any) begin
      case (host_req.idx)
        IDX_ACCESS_CTRL: host_rdata_d = ctrl_word;
        IDX_DATA_WINDOW: host_rdata_d = window_q;
        IDX_RAM_POINTER: host_rdata_d = pointer_q;
        default: host_rdata_d = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata_q <= READ_ZERO;
      host_rvalid_q <= 1'b0;
      cpu_view_q <= RST_ACCESS_CTRL;
      cons_rd_q <= 1'b0;
      cons_wr_q <= 1'b0;
    end else begin
      host_rdata_q <= host_rdata_d;
      host_rvalid_q <= rd_any;
      cpu_view_q <= ctrl_word;
      cons_rd_q <= ctrl_d.lock && ctrl_d.read_cmd;
      cons_wr_q <= ctrl_d.lock && ctrl_d.write_cmd;
    end
  end

  assign host_rdata = host_rdata_q;
  assign host_rvalid = host_rvalid_q;
  assign cpu_access_ctrl = cpu_view_q;
  assign consecutive_read = cons_rd_q;
  assign consecutive_write = cons_wr_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reserved_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    cpu_access_ctrl[31:8] == 24'h00_0000)
    else $error("upper control bits not zero");

  a_reserved_bits: assert property (
    @(posedge clk) disable iff (!rst_n)
    !cpu_access_ctrl[6] && !cpu_access_ctrl[4])
    else $error("reserved control bits not zero");

  a_single_write_once: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_ctrl && state_q == ST_IDLE && host_req.wdata[BIT_WRITE_CMD]
     && !host_req.wdata[BIT_LOCK])
    |=> ram_we ##1 (!ram_we && !ctrl_q.write_cmd))
    else $error("single write not done once and cleared");

  a_write_stores: assert property (
    @(posedge clk) disable iff (!rst_n)
    ram_we |=> u_ram.mem_q[$past(pointer_q[IDX_W+1:2])] == $past(window_q))
    else $error("ram write lost");

  a_single_read_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q == ST_RAM_READ && !ctrl_q.lock)
    |=> (window_q == $past(ram_rdata) && !ctrl_q.read_cmd))
    else $error("single read not loaded or not cleared");

  a_step_lock: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q != ST_IDLE && ctrl_q.lock)
    |=> pointer_q == ($past(ctrl_q.step_dir)
          ? $past(pointer_q) - 32'h0000_0004
          : $past(pointer_q) + 32'h0000_0004))
    else $error("pointer not stepped by four");

  a_no_step_unlock: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_q != ST_IDLE && !ctrl_q.lock) |=> $stable(pointer_q))
    else $error("pointer stepped without lock");

  a_lock_holds_cmd: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctrl_q.lock && ctrl_q.write_cmd && !wr_ctrl)
    |=> (ctrl_q.lock && ctrl_q.write_cmd))
    else $error("locked write command dropped");

  a_cons_read_next: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd_window && ctrl_q.lock && ctrl_q.read_cmd && state_q == ST_IDLE
     && !wr_ctrl && !host_req.wr) |=> state_q == ST_RAM_READ)
    else $error("consecutive read did not fetch");

  a_rs_high_ignored: assert property (
    @(posedge clk) disable iff (!rst_n)
    (register_select_pin && state_q == ST_IDLE) |=> $stable(ctrl_q))
    else $error("control changed with select pin high");
endmodule // host_ram_access_control

// file: testbench/host_model.sv
`timescale 1ns/100ps
module host_model
  import host_ram_pkg::*;
(
  input wire logic clk,
  output host_req_t host_req,
  output logic register_select_pin,
  input wire logic [31:0] host_rdata,
  input wire logic host_rvalid
);
  initial begin
    host_req = '0;
    register_select_pin = 1'b1;
  end

  // ----------------------------------------
  // register write, one strobe cycle
  // ----------------------------------------
  task automatic put(input logic [5:0] idx, input logic [31:0] d,
                     input logic sel_n = 1'b0);
    logic [31:0] v;
    v = d;
    if (idx == IDX_ACCESS_CTRL) begin
      v = d & 32'h0000_00a9;
      if (v[BIT_READ_CMD]) v[BIT_WRITE_CMD] = 1'b0;
    end
    @(posedge clk);
    host_req <= '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: v};
    register_select_pin <= sel_n;
    @(posedge clk);
    // released lines show the inverse, not the last value
    host_req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: ~v};
    register_select_pin <= 1'b1;
  endtask

  // ----------------------------------------
  // register read, answer one cycle later
  // ----------------------------------------
  task automatic get(input logic [5:0] idx, output logic [31:0] d);
    @(posedge clk);
    host_req <= '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 32'h0000_0000};
    register_select_pin <= 1'b0;
    @(posedge clk);
    host_req <= '{wr: 1'b0, rd: 1'b0, idx: ~idx, wdata: 32'hffff_ffff};
    register_select_pin <= 1'b1;
    // answer stands from the taking edge to this one
    @(posedge clk);
    d = (host_rvalid === 1'b1) ? host_rdata : 32'hxxxx_xxxx;
  endtask
endmodule // host_model

// file: testbench/host_ram_access_control_tb.sv
`timescale 1ns/100ps
module host_ram_access_control_tb;
  import host_ram_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  host_req_t host_req;
  logic register_select_pin;
  logic [31:0] host_rdata;
  logic [31:0] cpu_access_ctrl;
  logic [31:0] d;
  logic host_rvalid;
  logic consecutive_read;
  logic consecutive_write;
  int n_errors = 0;
  int n_checks = 0;

  always #4 clk = ~clk;

  host_ram_access_control dut_u (
    .clk(clk), .rst_n(rst_n), .host_req(host_req),
    .register_select_pin(register_select_pin), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .cpu_access_ctrl(cpu_access_ctrl),
    .consecutive_read(consecutive_read),
    .consecutive_write(consecutive_write)
  );
  host_model host_u (
    .clk(clk), .host_req(host_req),
    .register_select_pin(register_select_pin), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
    host_u.get(idx, d);
    chk(d, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk(cpu_access_ctrl, RST_ACCESS_CTRL);
    rchk(IDX_ACCESS_CTRL, RST_ACCESS_CTRL);
    $display("test reset done");
    // single write, then single read back
    host_u.put(IDX_DATA_WINDOW, 32'h1234_5678);
    host_u.put(IDX_RAM_POINTER, 32'h0000_0010);
    host_u.put(IDX_ACCESS_CTRL, 32'h0000_0020);
    rchk(IDX_ACCESS_CTRL, 32'h0000_0000);
    chk({31'h0, consecutive_write}, 32'h0000_0000);
    host_u.put(IDX_DATA_WINDOW, 32'h0000_0000);
    host_u.put(IDX_ACCESS_CTRL, 32'h0000_0008);
    rchk(IDX_DATA_WINDOW, 32'h1234_5678);
    rchk(IDX_ACCESS_CTRL, 32'h0000_0000);
    rchk(IDX_RAM_POINTER, 32'h0000_0010);
    $display("test single access done");
    // consecutive write, incrementing
    host_u.put(IDX_RAM_POINTER, 32'h0000_0020);
    host_u.put(IDX_DATA_WINDOW, 32'h0000_00a0);
    host_u.put(IDX_ACCESS_CTRL, 32'h0000_00a0);
    host_u.put(IDX_DATA_WINDOW, 32'h0000_00a1);
    chk({31'h0, consecutive_write}, 32'h0000_0001);
    rchk(IDX_ACCESS_CTRL, 32'h0000_00a0);
    chk(cpu_access_ctrl, 32'h0000_00a0);
    rchk(IDX_RAM_POINTER, 32'h0000_0028);
    host_u.put(IDX_ACCESS_CTRL, 32'h0000_0000, 1'b1);
    rchk(IDX_ACCESS_CTRL, 32'h0000_00a0);
    host_u.put(IDX_ACCESS_CTRL, 32'h0000_0000);
    rchk(IDX_ACCESS_CTRL, 32'h0000_0000);
    chk({31'h0, consecutive_write}, 32'h0000_0000);
    $display("test consecutive write done");
    // consecutive read, decrementing
    host_u.put(IDX_RAM_POINTER, 32'h0000_0024);
    host_u.put(IDX_ACCESS_CTRL, 32'h0000_0089);
    rchk(IDX_DATA_WINDOW, 32'h0000_00a1);
    chk({31'h0, consecutive_read}, 32'h0000_0001);
    rchk(IDX_DATA_WINDOW, 32'h0000_00a0);
    rchk(IDX_RAM_POINTER, 32'h0000_0018);
    host_u.put(IDX_ACCESS_CTRL, 32'h0000_0000);
    rchk(IDX_ACCESS_CTRL, 32'h0000_0000);
    chk({31'h0, consecutive_read}, 32'h0000_0000);
    // after lock clears a command acts once, pointer stays
    host_u.put(IDX_RAM_POINTER, 32'h0000_0040);
    host_u.put(IDX_DATA_WINDOW, 32'h0000_00b0);
    host_u.put(IDX_ACCESS_CTRL, 32'h0000_0020);
    rchk(IDX_RAM_POINTER, 32'h0000_0040);
    $display("test consecutive read done");
    tally_and_finish();
  end
endmodule // host_ram_access_control_tb
